// File: rtl/adc_sample_output_port.sv
// Converter output stage: sample, code, overrange flag, buffered stream
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01 - A sample is taken only on the rising conversion clock edge.
// RULE_02 - Code appears one clock cycle after the edge that sampled it.
// RULE_03 - Code is a 12-bit unsigned straight-binary value.
// RULE_04 - Overrange flag goes high when input exceeds full scale.
// RULE_05 - Overrange leaves the code at its normal all-ones value.
// RULE_06 - Clock source keeps each clock high phase at most 300 ns.
// RULE_07 - Clock source keeps duty cycle within 40 to 60 percent.
// RULE_08 - Capture registers code and flag together, one cycle late.
module adc_sample_output_port (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [12:0] analog_level,
  output logic [11:0]      sample_code,
  output logic             overrange_flag,
  output logic [12:0]      fifo_word,
  output logic             fifo_valid,
  input  wire logic        fifo_ready,
  output logic             sample_dropped
);
  // Analog level is modelled as a 13-bit quantised value; at or above
  // LEVEL_OVER the input sits past full scale.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } state_t;

  state_t      state_q;
  state_t      state_d;
  logic [12:0] held_q;
  logic [12:0] held_d;
  logic [11:0] code_q;
  logic [11:0] code_d;
  logic        over_q;
  logic        over_d;
  logic [12:0] word_q;
  logic [12:0] word_d;
  logic        wvalid_q;
  logic        wvalid_d;
  logic        drop_q;
  logic        drop_d;
  // Output register behind the buffer
  logic [12:0] fword_q;
  logic [12:0] fword_d;
  logic        fvalid_q;
  logic        fvalid_d;
  logic        out_take;

  stream_if #(.WIDTH(adc_pkg::WORD_W)) in_s ();
  stream_if #(.WIDTH(adc_pkg::WORD_W)) out_s ();

  function automatic logic past_full(input logic [12:0] lvl);
    logic over;
    over = (lvl >= adc_pkg::LEVEL_OVER);
    return over;
  endfunction : past_full

  function automatic logic [11:0] quantise(input logic [12:0] lvl);
    logic [11:0] code;
    // Saturates so the flag never disturbs the code bits
    if (past_full(lvl)) begin
      code = adc_pkg::CODE_FULL;                     // RULE_05
    end else begin
      code = lvl[11:0];                              // RULE_03
    end
    return code;
  endfunction : quantise

  assign in_s.valid  = wvalid_q;
  assign in_s.data   = word_q;
  // Pop only when the output register is empty or being read
  assign out_take    = !fvalid_q || fifo_ready;
  assign out_s.ready = out_take;

  // Sixteen words absorb a stalled reader; past that, words are lost
  sample_fifo #(
    .WIDTH (adc_pkg::WORD_W),
    .DEPTH (adc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk  (mclk),
    .reset (reset),
    .wr    (in_s),
    .rd    (out_s)
  );

  // The first edge after reset only arms the pipeline
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        state_d = ST_RUN;
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Sample taken at every rising edge
  always_comb begin
    held_d = analog_level;                           // RULE_01
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      held_q <= '0;
    end else begin
      held_q <= held_d;
    end
  end

  always_comb begin
    code_d = code_q;
    over_d = over_q;
    case (state_q)
      ST_IDLE: begin
        // Nothing has been held yet, so the reset code stands
        code_d = code_q;
        over_d = over_q;
      end
      ST_RUN: begin
        // The held sample becomes the output one edge later
        code_d = quantise(held_q);                   // RULE_02
        over_d = past_full(held_q);                  // RULE_04
      end
      default: begin
        code_d = code_q;
        over_d = over_q;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      code_q <= adc_pkg::CODE_RESET;
      over_q <= 1'b0;
    end else begin
      code_q <= code_d;
      over_q <= over_d;
    end
  end

  always_comb begin
    word_d   = word_q;
    wvalid_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        wvalid_d = 1'b0;
      end
      ST_RUN: begin
        // Flag rides as the top bit of the same word
        word_d   = {over_d, code_d};                 // RULE_08
        wvalid_d = 1'b1;
      end
      default: begin
        wvalid_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      word_q   <= '0;
      wvalid_q <= 1'b0;
    end else begin
      word_q   <= word_d;
      wvalid_q <= wvalid_d;
    end
  end

  always_comb begin
    // A full buffer cannot stall a converter, so the word is lost
    drop_d = wvalid_q && !in_s.ready;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      drop_q <= 1'b0;
    end else begin
      drop_q <= drop_d;
    end
  end

  always_comb begin
    fword_d  = fword_q;
    fvalid_d = fvalid_q;
    if (out_take) begin
      fword_d  = out_s.data;
      fvalid_d = out_s.valid;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      fword_q  <= '0;
      fvalid_q <= 1'b0;
    end else begin
      fword_q  <= fword_d;
      fvalid_q <= fvalid_d;
    end
  end

  // Every output comes straight from a register
  assign sample_code    = code_q;
  assign overrange_flag = over_q;
  assign fifo_word      = fword_q;
  assign fifo_valid     = fvalid_q;
  assign sample_dropped = drop_q;
endmodule : adc_sample_output_port

// File: rtl/adc_pkg.sv
// Constants shared by the converter output port design
package adc_pkg;
  localparam int unsigned CODE_W       = 12;
  localparam int unsigned WORD_W       = CODE_W + 1;
  localparam int unsigned FIFO_DEPTH   = 16;
  localparam logic [11:0] CODE_FULL    = 12'hfff;
  localparam logic [11:0] CODE_RESET   = 12'h000;
  localparam logic [12:0] LEVEL_OVER   = 13'h1000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned HIGH_MAX_NS   = 300;
  localparam int unsigned HIGH_MAX_CYC  = HIGH_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned LATENCY_CYC  = 1;
endpackage : adc_pkg

// File: rtl/stream_if.sv
// Valid and ready carrier for one sample word
`timescale 1ns/1ps
interface stream_if #(parameter int unsigned WIDTH = 13);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if

// File: rtl/sample_fifo.sv
// Word FIFO with valid and ready on both sides
`timescale 1ns/1ps
module sample_fifo #(
  parameter int unsigned WIDTH = 13,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic mclk,
  input  wire logic reset,
  stream_if.snk     wr,
  stream_if.src     rd
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_q != '0);
  assign rd.data  = mem[rp_q];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  always_comb begin
    wp_d  = push ? wp_q + 1'b1 : wp_q;
    rp_d  = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
    if (push) begin
      mem[wp_q] <= wr.data;
    end
  end
endmodule : sample_fifo

// File: tb/adc_port_assertions.sv
// Checker on the converter output port
`timescale 1ns/1ps
module adc_port_checker (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic [12:0] analog_level,
  input wire logic [11:0] sample_code,
  input wire logic        overrange_flag,
  input wire logic [12:0] fifo_word,
  input wire logic        fifo_valid
);
  logic [2:0] up_q;
  logic [2:0] up_d;
  logic       live;
  // Judge only once the pipeline holds post-reset samples
  always_comb up_d = (up_q == 3'h5) ? up_q : up_q + 3'h1;
  always_ff @(posedge mclk) up_q <= reset ? 3'h0 : up_d;
  assign live = (up_q == 3'h5);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_code_two_late: assert property (
    live |-> sample_code == ($past(analog_level[12], 2) ?
    adc_pkg::CODE_FULL : $past(analog_level[11:0], 2)))
    else $error("sample code wrong");
  a_flag_over: assert property (
    live |-> overrange_flag == $past(analog_level[12], 2))
    else $error("overrange flag wrong");
  a_over_full: assert property (
    overrange_flag |-> sample_code == adc_pkg::CODE_FULL)
    else $error("code not full on overrange");
  a_edge_only: assert property (
    live && $stable(analog_level) |->
    ##2 $stable({overrange_flag, sample_code}))
    else $error("output moved without new sample");
  a_word_over_full: assert property (
    fifo_valid && fifo_word[12] |-> fifo_word[11:0] == adc_pkg::CODE_FULL)
    else $error("buffered word not full on overrange");
  cover property ($rose(overrange_flag));
  cover property (live && sample_code == 12'h000);
  cover property (sample_code == 12'hfff && !overrange_flag);
endmodule : adc_port_checker

// File: tb/capture_model.sv
// Far-side capture logic: registers each word, paces the buffer
`timescale 1ns/1ps
module capture_model (
  input  wire logic        mclk,
  input  wire logic [11:0] sample_code,
  input  wire logic        overrange_flag,
  input  wire logic        stall,
  output logic             fifo_ready,
  output logic [12:0]      held_q
);
  always_ff @(posedge mclk) held_q <= {overrange_flag, sample_code};
  assign fifo_ready = !stall;
endmodule : capture_model

// File: tb/tb_top.sv
// Bench for the converter output port
`timescale 1ns/1ps
module tb_top;
  logic        mclk = 0, reset = 1, stall = 0, fifo_ready;
  logic [12:0] analog_level = 13'h1abc, held_q, fifo_word;
  logic [11:0] sample_code;
  logic        overrange_flag, fifo_valid, sample_dropped;
  int          errors = 0, checks = 0;
  always #50 mclk = ~mclk;
  adc_sample_output_port adc_sample_output_port_i (.mclk(mclk),
    .reset(reset), .analog_level(analog_level), .sample_code(sample_code),
    .overrange_flag(overrange_flag), .fifo_word(fifo_word),
    .fifo_valid(fifo_valid), .fifo_ready(fifo_ready),
    .sample_dropped(sample_dropped));
  capture_model capture_model_i (.mclk(mclk), .sample_code(sample_code),
    .overrange_flag(overrange_flag), .stall(stall),
    .fifo_ready(fifo_ready), .held_q(held_q));
  task automatic check(string n, logic [12:0] seen, logic [12:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task automatic sweep;
    logic [12:0] lv [6] = '{13'h0000, 13'h0001, 13'h0800, 13'h0fff,
                            13'h1000, 13'h1fff};
    logic [12:0] exp;
    foreach (lv[i]) begin
      exp = lv[i][12] ? {1'b1, adc_pkg::CODE_FULL} : lv[i];
      @(negedge mclk) analog_level = lv[i];
      repeat (4) @(negedge mclk);
      check("word", {overrange_flag, sample_code},
            exp);
      @(negedge mclk);
      check("captured", held_q, exp);
      check("fifo word", fifo_word, exp);
      check("fifo valid", 13'(fifo_valid), 13'h0001);
    end
  endtask : sweep
  task automatic fill;
    logic drop = 1'b0;
    stall = 1'b1;
    // Input never pauses, so a stalled reader must overflow
    repeat (24) begin
      @(negedge mclk);
      drop |= sample_dropped;
    end
    check("dropped", 13'(drop), 13'h0001);
    check("valid", 13'(fifo_valid), 13'h0001);
    stall = 1'b0;
    repeat (4) @(negedge mclk);
    check("drop stop", 13'(sample_dropped), 13'h0000);
    check("drained", fifo_word, {1'b1, adc_pkg::CODE_FULL});
  endtask : fill
  initial begin
    repeat (6) @(negedge mclk);
    check("reset", {overrange_flag, sample_code}, 13'h0000);
    check("reset valid", 13'(fifo_valid), 13'h0000);
    reset = 1'b0;
    sweep();
    fill();
    report_and_stop();
  end
  initial begin
    #200000;
    errors++;
    report_and_stop();
  end
endmodule : tb_top
bind adc_sample_output_port adc_port_checker adc_port_checker_i (
  .mclk(mclk), .reset(reset), .analog_level(analog_level),
  .sample_code(sample_code), .overrange_flag(overrange_flag),
  .fifo_word(fifo_word), .fifo_valid(fifo_valid));
